// file: rtl/altb_pkg.sv
// altb_pkg: offsets, reset values and carrier types of the alert limit bank.
// assumes a 16-bit register port, single clock, synchronous reset.
package altb_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ALTB_OFS_OVERCURRENT     = 8'h0C;
  localparam logic [7:0] ALTB_OFS_UNDERCURRENT    = 8'h0D;
  localparam logic [7:0] ALTB_OFS_BUS_OVERVOLTAGE = 8'h0E;
  localparam logic [7:0] ALTB_OFS_BUS_UNDERVOLT   = 8'h0F;
  localparam logic [7:0] ALTB_OFS_OVERTEMPERATURE = 8'h10;
  localparam logic [7:0] ALTB_OFS_OVERPOWER       = 8'h11;
  localparam logic [7:0] ALTB_OFS_MAKER_ID        = 8'h3E;

  // ==========================================================================
  // reset values and field masks
  localparam logic [15:0] ALTB_RST_OVERCURRENT     = 16'h7FFF;
  localparam logic [15:0] ALTB_RST_UNDERCURRENT    = 16'h8000;
  localparam logic [15:0] ALTB_RST_BUS_OVERVOLTAGE = 16'h7FFF;
  localparam logic [15:0] ALTB_RST_BUS_UNDERVOLT   = 16'h0000;
  localparam logic [15:0] ALTB_RST_OVERTEMPERATURE = 16'h7FF0;
  localparam logic [15:0] ALTB_RST_OVERPOWER       = 16'hFFFF;
  localparam logic [15:0] ALTB_MASK_BUS_VOLTAGE    = 16'h7FFF;
  localparam logic [15:0] ALTB_MASK_TEMPERATURE    = 16'hFFF0;
  // arbitrary neutral maker code
  localparam logic [15:0] ALTB_MAKER_CODE_DEFAULT  = 16'h5A5A;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } altb_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] current;
    logic [15:0] bus_voltage;
    logic [15:0] die_temperature_result;
    logic [15:0] power;
  } altb_meas_t;

  typedef struct packed {
    logic overcurrent_flag;
    logic undercurrent_flag;
    logic bus_overvoltage_flag;
    logic bus_undervoltage_flag;
    logic overtemperature_flag;
    logic power_limit_field;
  } altb_flags_t;

endpackage

// file: rtl/altb_limit_flag.sv
// altb_limit_flag: one limit comparator and its alert flag.
// assumes samples arrive with a one-cycle valid strobe on the same clock.
`timescale 1ns/100ps
module altb_limit_flag
  import altb_pkg::*;
#(
  parameter int  WIDTH  = 16,
  parameter bit  SIGNED = 1'b1,
  parameter bit  ABOVE  = 1'b1
)(
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  input  wire logic             sample_valid_in,
  input  wire logic [WIDTH-1:0] sample_in,
  input  wire logic [WIDTH-1:0] limit_in,
  input  wire logic             latch_in,
  input  wire logic             flag_read_in,
  output logic                  flag_out
);

  logic fault;
  logic next_flag;

  // ==========================================================================
  // compare
  always_comb
  begin
    if (SIGNED)
      fault = ABOVE ? ($signed(sample_in) > $signed(limit_in))
                    : ($signed(sample_in) < $signed(limit_in));
    else
      fault = ABOVE ? (sample_in > limit_in) : (sample_in < limit_in);
  end

  // set wins over the read clear, so a fault in the read cycle is kept
  always_comb
  begin
    next_flag = flag_out;
    if (latch_in)
    begin
      if (flag_read_in)
        next_flag = 1'b0;
      if (sample_valid_in && fault)
        next_flag = 1'b1;
    end
    else if (sample_valid_in)
      next_flag = fault;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      flag_out <= 1'b0;
    else
      flag_out <= next_flag;
  end

  a_flag_on_fault: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    sample_valid_in && fault |=> flag_out)
    else $error("flag not raised on fault");

  a_latched_flag_holds: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    latch_in && flag_out && !flag_read_in |=> flag_out)
    else $error("latched flag dropped without read");

  a_transparent_clears: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !latch_in && sample_valid_in && !fault |=> !flag_out)
    else $error("transparent flag did not clear");

endmodule

// file: rtl/altb_alert_limit_bank.sv
// altb_alert_limit_bank: threshold registers, maker code and limit flags.
// assumes a serial bus engine gives one-cycle read/write strobes with address.
// Function
// - negative over-current limit trips the alarm even at zero current.
// - over-current limit 16-bit signed read/write, reset 7FFF, 1.2 mA per step.
// - under-current limit 16-bit signed read/write, reset 8000, 1.2 mA per step.
// - bus over-voltage limit 15-bit unsigned, reset 7FFF, 3.125 mV per step.
// - bus under-voltage limit 15-bit unsigned, reset zero, 3.125 mV per step.
// - bit 15 of both bus voltage limits reads zero.
// - temperature limit signed in bits 15..4, compared with die temperature.
// - temperature limit bits 3..0 always read zero.
// - power limit 16-bit unsigned, reset FFFF, compared with power result.
// - read-only 16-bit maker code returns a fixed value.
// - limits decode at 0C..11, maker code at 3E.
// - over-current and under-current flags set on matching comparison.
// - latched flags hold until flag register read; transparent flags follow fault.
// - a select bit chooses raw samples or averaged results for comparison.
`timescale 1ns/100ps
module altb_alert_limit_bank
  import altb_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = ALTB_MAKER_CODE_DEFAULT
)(
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire altb_req_t   req_in,
  input  wire altb_meas_t  raw_meas_in,
  input  wire altb_meas_t  avg_meas_in,
  input  wire logic        alert_latch_select_in,
  input  wire logic        averaged_compare_select_in,
  input  wire logic        flag_register_read_in,
  output altb_flags_t      flags_out,
  output logic [15:0]      rdata_out,
  output logic             rvalid_out
);

  typedef struct packed {
    logic [15:0] overcurrent_limit;
    logic [15:0] undercurrent_limit;
    logic [15:0] bus_overvoltage_limit;
    logic [15:0] bus_undervoltage_limit;
    logic [15:0] overtemperature_limit;
    logic [15:0] overpower_limit;
    logic [15:0] rdata;
    logic        rvalid;
  } altb_state_t;

  altb_state_t state;
  altb_state_t next_state;
  altb_meas_t  meas;
  logic [15:0] read_mux;

  // ==========================================================================
  // sample select
  always_comb
  begin
    meas = averaged_compare_select_in ? avg_meas_in : raw_meas_in;
  end

  // ==========================================================================
  // read decode
  always_comb
  begin
    if (req_in.addr == ALTB_OFS_OVERCURRENT)
      read_mux = state.overcurrent_limit;
    else if (req_in.addr == ALTB_OFS_UNDERCURRENT)
      read_mux = state.undercurrent_limit;
    else if (req_in.addr == ALTB_OFS_BUS_OVERVOLTAGE)
      read_mux = state.bus_overvoltage_limit & ALTB_MASK_BUS_VOLTAGE;
    else if (req_in.addr == ALTB_OFS_BUS_UNDERVOLT)
      read_mux = state.bus_undervoltage_limit & ALTB_MASK_BUS_VOLTAGE;
    else if (req_in.addr == ALTB_OFS_OVERTEMPERATURE)
      read_mux = state.overtemperature_limit & ALTB_MASK_TEMPERATURE;
    else if (req_in.addr == ALTB_OFS_OVERPOWER)
      read_mux = state.overpower_limit;
    else if (req_in.addr == ALTB_OFS_MAKER_ID)
      read_mux = MAKER_CODE;
    else
      read_mux = 16'h0000;
  end

  // ==========================================================================
  // register writes
  always_comb
  begin
    next_state = state;
    next_state.rvalid = req_in.read;
    if (req_in.read)
      next_state.rdata = read_mux;
    if (req_in.write)
    begin
      if (req_in.addr == ALTB_OFS_OVERCURRENT)
        next_state.overcurrent_limit = req_in.wdata;
      else if (req_in.addr == ALTB_OFS_UNDERCURRENT)
        next_state.undercurrent_limit = req_in.wdata;
      else if (req_in.addr == ALTB_OFS_BUS_OVERVOLTAGE)
        next_state.bus_overvoltage_limit = req_in.wdata & ALTB_MASK_BUS_VOLTAGE;
      else if (req_in.addr == ALTB_OFS_BUS_UNDERVOLT)
        next_state.bus_undervoltage_limit = req_in.wdata & ALTB_MASK_BUS_VOLTAGE;
      else if (req_in.addr == ALTB_OFS_OVERTEMPERATURE)
        next_state.overtemperature_limit = req_in.wdata & ALTB_MASK_TEMPERATURE;
      else if (req_in.addr == ALTB_OFS_OVERPOWER)
        next_state.overpower_limit = req_in.wdata;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      state.overcurrent_limit      <= ALTB_RST_OVERCURRENT;
      state.undercurrent_limit     <= ALTB_RST_UNDERCURRENT;
      state.bus_overvoltage_limit  <= ALTB_RST_BUS_OVERVOLTAGE;
      state.bus_undervoltage_limit <= ALTB_RST_BUS_UNDERVOLT;
      state.overtemperature_limit  <= ALTB_RST_OVERTEMPERATURE;
      state.overpower_limit        <= ALTB_RST_OVERPOWER;
      state.rdata                  <= 16'h0000;
      state.rvalid                 <= 1'b0;
    end
    else
      state <= next_state;
  end

  assign rdata_out  = state.rdata;
  assign rvalid_out = state.rvalid;

  // ==========================================================================
  // comparators; temperature low nibble is zero in the limit operand only, the sample is compared unmasked
  altb_limit_flag #(.WIDTH(16), .SIGNED(1'b1), .ABOVE(1'b1)) u_overcurrent (
    .clock_in       (clock_in),
    .sys_rst_in     (sys_rst_in),
    .sample_valid_in(meas.valid),
    .sample_in      (meas.current),
    .limit_in       (state.overcurrent_limit),
    .latch_in       (alert_latch_select_in),
    .flag_read_in   (flag_register_read_in),
    .flag_out       (flags_out.overcurrent_flag)
  );
  altb_limit_flag #(.WIDTH(16), .SIGNED(1'b1), .ABOVE(1'b0)) u_undercurrent (
    .clock_in       (clock_in),
    .sys_rst_in     (sys_rst_in),
    .sample_valid_in(meas.valid),
    .sample_in      (meas.current),
    .limit_in       (state.undercurrent_limit),
    .latch_in       (alert_latch_select_in),
    .flag_read_in   (flag_register_read_in),
    .flag_out       (flags_out.undercurrent_flag)
  );
  altb_limit_flag #(.WIDTH(16), .SIGNED(1'b0), .ABOVE(1'b1)) u_bus_over (
    .clock_in       (clock_in),
    .sys_rst_in     (sys_rst_in),
    .sample_valid_in(meas.valid),
    .sample_in      (meas.bus_voltage),
    .limit_in       (state.bus_overvoltage_limit),
    .latch_in       (alert_latch_select_in),
    .flag_read_in   (flag_register_read_in),
    .flag_out       (flags_out.bus_overvoltage_flag)
  );
  altb_limit_flag #(.WIDTH(16), .SIGNED(1'b0), .ABOVE(1'b0)) u_bus_under (
    .clock_in       (clock_in),
    .sys_rst_in     (sys_rst_in),
    .sample_valid_in(meas.valid),
    .sample_in      (meas.bus_voltage),
    .limit_in       (state.bus_undervoltage_limit),
    .latch_in       (alert_latch_select_in),
    .flag_read_in   (flag_register_read_in),
    .flag_out       (flags_out.bus_undervoltage_flag)
  );
  altb_limit_flag #(.WIDTH(16), .SIGNED(1'b1), .ABOVE(1'b1)) u_overtemp (
    .clock_in       (clock_in),
    .sys_rst_in     (sys_rst_in),
    .sample_valid_in(meas.valid),
    .sample_in      (meas.die_temperature_result),
    .limit_in       (state.overtemperature_limit),
    .latch_in       (alert_latch_select_in),
    .flag_read_in   (flag_register_read_in),
    .flag_out       (flags_out.overtemperature_flag)
  );
  altb_limit_flag #(.WIDTH(16), .SIGNED(1'b0), .ABOVE(1'b1)) u_overpower (
    .clock_in       (clock_in),
    .sys_rst_in     (sys_rst_in),
    .sample_valid_in(meas.valid),
    .sample_in      (meas.power),
    .limit_in       (state.overpower_limit),
    .latch_in       (alert_latch_select_in),
    .flag_read_in   (flag_register_read_in),
    .flag_out       (flags_out.power_limit_field)
  );

  // ==========================================================================
  // checks
  sequence s_write_bus_over;
    req_in.write && req_in.addr == ALTB_OFS_BUS_OVERVOLTAGE;
  endsequence

  a_bus_reserved_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_write_bus_over |=> !state.bus_overvoltage_limit[15])
    else $error("bus limit reserved bit set");

  a_temp_nibble_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    state.overtemperature_limit[3:0] == 4'h0)
    else $error("temperature reserved bits set");

  a_maker_read: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    req_in.read && req_in.addr == ALTB_OFS_MAKER_ID |=> rdata_out == MAKER_CODE)
    else $error("maker code wrong");

  sequence s_write_oc;
    req_in.write && req_in.addr == ALTB_OFS_OVERCURRENT;
  endsequence

  sequence s_read_oc;
    req_in.read && req_in.addr == ALTB_OFS_OVERCURRENT;
  endsequence

  // a read right behind a write must already see the new limit
  a_oc_write_readback: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_write_oc ##1 s_read_oc |=> rdata_out == $past(req_in.wdata, 2))
    else $error("over-current limit readback wrong");

  a_neg_limit_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    meas.valid && meas.current == 16'h0000 && state.overcurrent_limit[15]
    |=> flags_out.overcurrent_flag)
    else $error("negative limit did not trip at zero");

  a_read_valid: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    req_in.read |=> rvalid_out ##1 !rvalid_out || $past(req_in.read))
    else $error("read answer timing wrong");

endmodule

// file: verif/altb_host_model.sv
// altb_host_model: register host facing the alert limit bank.
// assumes one-cycle strobes taken on the rising edge; drives on the falling edge.
`timescale 1ns/100ps
module altb_host_model
  import altb_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rvalid_in,
  input  wire logic [15:0] rdata_in,
  output altb_req_t        req_out
);
  // ==========================================================================
  // bus release
  initial req_out = '0;

  // released lines show the inverse, so a stale value is never taken for a good one
  task automatic drop();
    req_out.write = 1'b0;
    req_out.read  = 1'b0;
    req_out.addr  = ~req_out.addr;
    req_out.wdata = ~req_out.wdata;
  endtask

  // ==========================================================================
  // transfers
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock_in);
    req_out = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(negedge clock_in);
    drop();
  endtask

  // write strobe followed at once by a read strobe of the same offset
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] dw, output logic [15:0] d);
    @(negedge clock_in);
    req_out = '{write: 1'b1, read: 1'b0, addr: a, wdata: dw};
    @(negedge clock_in);
    req_out = '{write: 1'b0, read: 1'b1, addr: a, wdata: dw};
    @(negedge clock_in);
    drop();
    d = (rvalid_in === 1'b1) ? rdata_in : 16'hXXXX;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
    int n;
    @(negedge clock_in);
    req_out = '{write: 1'b0, read: 1'b1, addr: a, wdata: req_out.wdata};
    @(negedge clock_in);
    drop();
    ok = 1'b0;
    d  = 16'hXXXX;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (rvalid_in === 1'b1)
      begin
        ok = 1'b1;
        d  = rdata_in;
      end
      else
        @(negedge clock_in);
    end
  endtask
endmodule

// file: verif/tb.sv
// tb: register and limit-flag checks of the alert limit bank.
// assumes the host model for register traffic; measurements driven here.
`timescale 1ns/100ps
module tb;
  import altb_pkg::*;
  // arbitrary maker code for this bench
  localparam logic [15:0] TB_MAKER = 16'h3C96;

  logic        clock_in;
  logic        sys_rst_in;
  logic        latch_sel;
  logic        avg_sel;
  logic        flag_rd;
  logic        rvalid;
  logic [15:0] rdata;
  logic [15:0] rd_word;
  altb_req_t   req;
  altb_meas_t  raw_meas;
  altb_meas_t  avg_meas;
  altb_flags_t flags;
  int          err_count;
  int          samples_checked;

  logic [7:0]  ofs   [6] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11};
  logic [15:0] rstv  [6] = '{16'h7FFF, 16'h8000, 16'h7FFF, 16'h0000, 16'h7FF0, 16'hFFFF};
  logic [15:0] onesv [6] = '{16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h7FFF, 16'hFFF0, 16'hFFFF};

  altb_alert_limit_bank #(.MAKER_CODE(TB_MAKER)) dut_u (
    .clock_in                   (clock_in),
    .sys_rst_in                 (sys_rst_in),
    .req_in                     (req),
    .raw_meas_in                (raw_meas),
    .avg_meas_in                (avg_meas),
    .alert_latch_select_in      (latch_sel),
    .averaged_compare_select_in (avg_sel),
    .flag_register_read_in      (flag_rd),
    .flags_out                  (flags),
    .rdata_out                  (rdata),
    .rvalid_out                 (rvalid)
  );

  altb_host_model host_u (
    .clock_in  (clock_in),
    .rvalid_in (rvalid),
    .rdata_in  (rdata),
    .req_out   (req)
  );

  // ==========================================================================
  // helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    bit          ok;
    host_u.rd(a, d, ok);
    check({15'h0000, ok}, 16'h0001, "read answer");
    check(d, exp, "read data");
  endtask

  function automatic altb_meas_t mk(input logic [15:0] c, v, t, p);
    return '{valid: 1'b1, current: c, bus_voltage: v, die_temperature_result: t, power: p};
  endfunction

  // flag order: over, under, bus over, bus under, temperature, power
  task automatic sample(input altb_meas_t m, input logic to_avg, input logic [5:0] exp);
    @(negedge clock_in);
    if (to_avg)
      avg_meas = m;
    else
      raw_meas = m;
    @(negedge clock_in);
    raw_meas.valid = 1'b0;
    avg_meas.valid = 1'b0;
    check({10'h000, flags}, {10'h000, exp}, "flags");
  endtask

  task automatic flag_pulse(input logic [5:0] exp);
    @(negedge clock_in);
    flag_rd = 1'b1;
    @(negedge clock_in);
    flag_rd = 1'b0;
    check({10'h000, flags}, {10'h000, exp}, "flags after read");
  endtask

  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // clock and watchdog
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  initial
  begin
    #500us;
    err_count++;
    give_verdict();
  end

  // ==========================================================================
  // tests
  initial
  begin
    sys_rst_in = 1'b1;
    latch_sel  = 1'b0;
    avg_sel    = 1'b0;
    flag_rd    = 1'b0;
    raw_meas   = '0;
    avg_meas   = '0;
    repeat (10) @(negedge clock_in);
    sys_rst_in = 1'b0;
    for (int i = 0; i < 6; i++)
      rd_chk(ofs[i], rstv[i]);
    rd_chk(8'h3E, TB_MAKER);
    rd_chk(8'h3F, 16'h0000);
    for (int i = 0; i < 6; i++)
      host_u.wr(ofs[i], 16'hFFFF);
    for (int i = 0; i < 6; i++)
      rd_chk(ofs[i], onesv[i]);
    host_u.wr(8'h3E, 16'h0000);
    rd_chk(8'h3E, TB_MAKER);
    // limits: over -1, under -2, bus 0100/0080, temperature 0100, power 1000
    host_u.wr(8'h0D, 16'hFFFE);
    host_u.wr(8'h0E, 16'h0100);
    host_u.wr(8'h0F, 16'h0080);
    host_u.wr(8'h10, 16'h0105);
    host_u.wr(8'h11, 16'h1000);
    rd_chk(8'h10, 16'h0100);
    sample(mk(16'h0000, 16'h0100, 16'h0000, 16'h1000), 1'b0, 6'b100000);
    sample(mk(16'hFFFD, 16'h8000, 16'hFF00, 16'h8000), 1'b0, 6'b011001);
    sample(mk(16'hFFFE, 16'h0040, 16'h0110, 16'h0000), 1'b0, 6'b000110);
    flag_pulse(6'b000110);
    latch_sel = 1'b1;
    // bus under and temperature flags from the last transparent sample stay latched
    sample(mk(16'h0000, 16'h0100, 16'h0000, 16'h0000), 1'b0, 6'b100110);
    sample(mk(16'hFFFE, 16'h0100, 16'h0000, 16'h0000), 1'b0, 6'b100110);
    flag_pulse(6'b000000);
    latch_sel = 1'b0;
    avg_sel   = 1'b1;
    sample(mk(16'h0000, 16'h0100, 16'h0000, 16'h0000), 1'b0, 6'b000000);
    sample(mk(16'h0000, 16'h0100, 16'h0000, 16'h0000), 1'b1, 6'b100000);
    host_u.wr_rd(8'h0C, 16'h8000, rd_word);
    check(rd_word, 16'h8000, "write then read");
    give_verdict();
  end
endmodule
